// [fp_unit_params.svh]
`ifndef FP_UNIT_PARAMS_SVH
`define FP_UNIT_PARAMS_SVH
// Operation word layout
`define FP_LINE_NIB 4'hf
`define FP_ID_DEFAULT 3'h1
`define FP_CLS_GEN 3'h0
`define FP_CLS_TRAP 6'h0f
`define FP_OPM_POW10 7'h12
// Effective address modes and registers
`define FP_EA_DREG 3'h0
`define FP_EA_AREG 3'h1
`define FP_EA_EXT 3'h7
`define FP_EA_IMM 3'h4
// Trap operand modes
`define FP_TM_WORD 3'h2
`define FP_TM_LONG 3'h3
`define FP_TM_NONE 3'h4
// Extended format constants
`define FP_EXT_BIAS 15'h3fff
`define FP_EXP_MAX 15'h7fff
`define FP_SGL_BIAS 15'h007f
`define FP_DBL_BIAS 15'h03ff
`define FP_ONE_MANT 64'h8000_0000_0000_0000
`define FP_TENTH_MANT 64'hcccc_cccc_cccc_cccd
`define FP_POW_MAX_EXP 16'h000b
// Exception byte bits
`define FP_EXC_UNORDERED_BRANCH_FLAG 7
`define FP_EXC_SIGNALING_NOT_A_NUMBER_FLAG 6
`define FP_EXC_OPERAND_ERROR_FLAG 5
`define FP_EXC_OVERFLOW_FLAG 4
`define FP_EXC_UNDERFLOW_FLAG 3
`define FP_EXC_DZ 2
`define FP_EXC_RESULT_INEXACT_FLAG 1
`define FP_EXC_DECIMAL_INPUT_INEXACT_FLAG 0
// Accrued byte bits
`define FP_ACC_IOP 7
`define FP_ACC_OVERFLOW_FLAG 6
`define FP_ACC_UNDERFLOW_FLAG 5
`define FP_ACC_DZ 4
`define FP_ACC_INEX 3
// Condition code bits
`define FP_CC_N 3
`define FP_CC_Z 2
`define FP_CC_I 1
`define FP_CC_NAN 0
// Host APB register offsets
`define FP_REG_CMD 8'h00
`define FP_REG_OPND0 8'h04
`define FP_REG_OPND1 8'h08
`define FP_REG_OPND2 8'h0c
`define FP_REG_STAT 8'h10
`define FP_REG_CFG 8'h14
`endif

// [fp_unit_pkg.sv]
package fp_unit_pkg;
  typedef enum logic [2:0] {
    FMT_LONG = 3'b000,
    FMT_SINGLE = 3'b001,
    FMT_EXT = 3'b010,
    FMT_PACKED = 3'b011,
    FMT_WORD = 3'b100,
    FMT_DOUBLE = 3'b101,
    FMT_BYTE = 3'b110
  } fmt_e;
  typedef enum logic [2:0] {
    RESP_DONE = 3'b000,
    RESP_TRAP = 3'b001,
    RESP_NOTRAP = 3'b010,
    RESP_UNORDERED_BRANCH_FLAG = 3'b011,
    RESP_ILLEGAL = 3'b100,
    RESP_FOREIGN = 3'b101
  } resp_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC = 3'b001,
    ST_OPND = 3'b010,
    ST_EXEC = 3'b011,
    ST_RESP = 3'b100
  } dev_state_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_CMD = 2'b01,
    H_WAIT = 2'b10
  } host_state_e;
endpackage

// [fp_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface fp_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [15:0] op_word;
  logic [15:0] ext_word;
  logic opnd_req;
  logic opnd_valid;
  logic [95:0] opnd_data;
  logic resp_valid;
  fp_unit_pkg::resp_e resp_code;
  logic [1:0] resp_words;
  modport dev(input cmd_valid, op_word, ext_word, opnd_valid, opnd_data,
    output cmd_ready, opnd_req, resp_valid, resp_code, resp_words);
  modport host(output cmd_valid, op_word, ext_word, opnd_valid, opnd_data,
    input cmd_ready, opnd_req, resp_valid, resp_code, resp_words);
endinterface
`default_nettype wire

// [fp_pow10_trap_dev.sv]
// What this block does
// RULE1: Ten to the source power into destination
// RULE2: Zero gives one, infinities give inf or zero
// RULE3: Act only on own coprocessor identifier
// RULE4: Register source needs zeroed address field
// RULE5: Memory source; data-direct limited, address-direct illegal
// RULE6: Decode indirect modes and mode seven registers
// RULE7: Source specifier selects memory operand format
// RULE8: Register source specifier names source register
// RULE9: Equal fields read and write one register
// RULE10: Clear unordered, operand, divide flags; quotient kept
// RULE11: True condition makes host take trap
// RULE12: False condition continues with next instruction
// RULE13: Predicate picks one of thirty-two tests
// RULE14: Optional trap operand words serve handler only
// RULE15: Unordered flag on NaN with non-aware test
// RULE16: Unordered sets accrued invalid; others untouched
// RULE17: Trap mode gives one, two or no words
// RULE18: Unordered exception taken before instruction by host
// RULE19: NaN source gives NaN, signaling flagged
`timescale 1ns/100ps
`default_nettype none
`include "fp_unit_params.svh"
module fp_pow10_trap_dev #(
  parameter logic [2:0] COPROC_ID = `FP_ID_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic reset,
  fp_link_if.dev link,
  input wire logic unordered_branch_flag_trap_en,
  input wire logic cc_load,
  input wire logic [3:0] cc_in,
  input wire logic [2:0] reg_sel,
  output logic [79:0] reg_data,
  output logic [7:0] exc_byte,
  output logic [7:0] accr_byte,
  output logic [3:0] cond_codes,
  output logic [7:0] quot_byte
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [6:0] lz64(input logic [63:0] v);
    logic [6:0] n;
    logic hit;
    n = 7'h40;
    hit = 1'b0;
    for (int i = 63; i >= 0; i--)
    begin
      if (v[i] && !hit)
      begin
        n = 7'(63 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  function automatic logic [79:0] to_ext(input logic [2:0] f,
                                         input logic [95:0] d);
    logic s;
    logic [14:0] e;
    logic [63:0] m;
    logic [63:0] iv;
    logic [6:0] lz;
    s = 1'b0;
    e = 15'h0;
    m = 64'h0;
    iv = 64'h0;
    lz = 7'h0;
    case (f)
      fp_unit_pkg::FMT_BYTE: iv = {{56{d[7]}}, d[7:0]};
      fp_unit_pkg::FMT_WORD: iv = {{48{d[15]}}, d[15:0]};
      default: iv = {{32{d[31]}}, d[31:0]};
    endcase
    case (f)
      fp_unit_pkg::FMT_SINGLE:
      begin
        s = d[31];
        m = {1'b1, d[22:0], 40'h0};
        e = 15'(d[30:23]) - `FP_SGL_BIAS + `FP_EXT_BIAS;
        if (d[30:23] == 8'hff)
        begin
          e = `FP_EXP_MAX;
          m = (d[22:0] == 23'h0) ? 64'h0 : m;
        end else if (d[30:23] == 8'h0)
        begin
          m[63] = 1'b0;
          e = `FP_EXT_BIAS - `FP_SGL_BIAS + 15'h1;
        end
      end
      fp_unit_pkg::FMT_DOUBLE:
      begin
        s = d[63];
        m = {1'b1, d[51:0], 11'h0};
        e = 15'(d[62:52]) - `FP_DBL_BIAS + `FP_EXT_BIAS;
        if (d[62:52] == 11'h7ff)
        begin
          e = `FP_EXP_MAX;
          m = (d[51:0] == 52'h0) ? 64'h0 : m;
        end else if (d[62:52] == 11'h0)
        begin
          m[63] = 1'b0;
          e = `FP_EXT_BIAS - `FP_DBL_BIAS + 15'h1;
        end
      end
      fp_unit_pkg::FMT_EXT:
      begin
        s = d[95];
        e = d[94:80];
        m = d[63:0];
      end
      default:
      begin
        s = iv[63];
        m = s ? 64'(-iv) : iv;
        e = `FP_EXT_BIAS + 15'h3f;
      end
    endcase
    if (e != `FP_EXP_MAX && f != fp_unit_pkg::FMT_EXT)
    begin
      lz = lz64(m);
      if (m == 64'h0)
        e = 15'h0;
      else
      begin
        e = e - 15'(lz);
        m = m << lz;
      end
    end
    return {s, e, m};
  endfunction

  // Low three predicate bits pick equal/greater/less, bit 3 adds unordered
  function automatic logic pred_true(input logic [4:0] p,
                                     input logic [3:0] cc);
    logic not_a_number_cc;
    logic eq;
    logic gt;
    logic lt;
    not_a_number_cc = cc[`FP_CC_NAN];
    eq = cc[`FP_CC_Z] && !not_a_number_cc;
    gt = !cc[`FP_CC_Z] && !cc[`FP_CC_N] && !not_a_number_cc;
    lt = !cc[`FP_CC_Z] && cc[`FP_CC_N] && !not_a_number_cc;
    return (p[0] && eq) || (p[1] && gt) || (p[2] && lt) || (p[3] && not_a_number_cc);
  endfunction

  function automatic logic [3:0] cc_of(input logic [79:0] r);
    logic inf;
    inf = r[78:64] == `FP_EXP_MAX;
    return {r[79], r[78:0] == 79'h0, inf && r[62:0] == 63'h0,
            inf && r[62:0] != 63'h0};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  fp_unit_pkg::dev_state_e st_ff, nxt_st;
  fp_unit_pkg::resp_e code_ff, nxt_code;
  logic [15:0] op_ff, nxt_op, ext_ff, nxt_ext;
  logic [79:0] fpr_ff [8];
  logic [79:0] nxt_fpr [8];
  logic [7:0] exc_ff, nxt_exc, accr_ff, nxt_accr, quot_ff;
  logic [3:0] cc_ff, nxt_cc;
  logic [63:0] m_ff, nxt_m;
  logic [14:0] e_ff, nxt_e;
  logic [12:0] cnt_ff, nxt_cnt;
  logic neg_ff, nxt_neg, inex_ff, nxt_inex;
  logic [1:0] words_ff, nxt_words;

  logic [2:0] fmt, src, dst, ea_mode, ea_reg;
  logic id_ok, is_gen, is_trap, ea_ok, unordered_branch_flag;
  logic go, fin, ovf, unf, signaling_not_a_number_flag, fr_nz;
  logic [79:0] x, res;
  logic [15:0] ue;
  logic [67:0] p10;
  logic [127:0] p01;

  assign fmt = ext_ff[12:10];
  assign src = ext_ff[12:10];
  assign dst = ext_ff[9:7];
  assign ea_mode = op_ff[5:3];
  assign ea_reg = op_ff[2:0];
  assign id_ok = op_ff[15:12] == `FP_LINE_NIB
                 && op_ff[11:9] == COPROC_ID; // RULE3
  assign is_gen = op_ff[8:6] == `FP_CLS_GEN && !ext_ff[15] && !ext_ff[13]
                  && ext_ff[6:0] == `FP_OPM_POW10;
  assign is_trap = op_ff[8:3] == `FP_CLS_TRAP && ext_ff[15:5] == 11'h0
                   && (ea_reg == `FP_TM_WORD || ea_reg == `FP_TM_LONG
                   || ea_reg == `FP_TM_NONE); // RULE17
  // Address-direct never legal; data-direct only for narrow formats
  assign ea_ok = (ea_mode == `FP_EA_AREG) ? 1'b0 : // RULE5
                 (ea_mode == `FP_EA_DREG) ? (fmt == fp_unit_pkg::FMT_LONG
                   || fmt == fp_unit_pkg::FMT_SINGLE
                   || fmt == fp_unit_pkg::FMT_WORD
                   || fmt == fp_unit_pkg::FMT_BYTE) :
                 (ea_mode == `FP_EA_EXT) ? (ea_reg <= `FP_EA_IMM) : 1'b1; // RULE6
  assign unordered_branch_flag = cc_ff[`FP_CC_NAN] && ext_ff[4]; // RULE15
  assign x = (st_ff == fp_unit_pkg::ST_OPND) ? to_ext(fmt, link.opnd_data)
             : fpr_ff[src]; // RULE7 RULE8 RULE9
  assign p10 = {4'h0, m_ff} * 68'ha;
  assign p01 = {64'h0, m_ff} * {64'h0, `FP_TENTH_MANT};

  assign link.cmd_ready = st_ff == fp_unit_pkg::ST_IDLE;
  assign link.opnd_req = st_ff == fp_unit_pkg::ST_OPND;
  assign link.resp_valid = st_ff == fp_unit_pkg::ST_RESP;
  assign link.resp_code = code_ff;
  assign link.resp_words = words_ff;
  assign reg_data = fpr_ff[reg_sel];
  assign exc_byte = exc_ff;
  assign accr_byte = accr_ff;
  assign cond_codes = cc_ff;
  assign quot_byte = quot_ff; // RULE10

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_code = code_ff;
    nxt_op = op_ff;
    nxt_ext = ext_ff;
    nxt_fpr = fpr_ff;
    nxt_exc = exc_ff;
    nxt_accr = accr_ff;
    nxt_cc = cc_ff;
    nxt_m = m_ff;
    nxt_e = e_ff;
    nxt_cnt = cnt_ff;
    nxt_neg = neg_ff;
    nxt_inex = inex_ff;
    nxt_words = words_ff;
    go = 1'b0;
    fin = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    signaling_not_a_number_flag = 1'b0;
    res = 80'h0;
    ue = 16'({1'b0, x[78:64]}) - 16'({1'b0, `FP_EXT_BIAS});
    fr_nz = 1'b0;
    case (st_ff)
      fp_unit_pkg::ST_IDLE:
      begin
        if (cc_load)
          nxt_cc = cc_in;
        if (link.cmd_valid)
        begin
          nxt_op = link.op_word;
          nxt_ext = link.ext_word;
          nxt_st = fp_unit_pkg::ST_DEC;
        end
      end
      fp_unit_pkg::ST_DEC:
      begin
        nxt_st = fp_unit_pkg::ST_RESP;
        nxt_words = 2'h0;
        if (!id_ok)
          nxt_code = fp_unit_pkg::RESP_FOREIGN; // RULE3
        else if (is_trap)
        begin
          // Trap touches only the unordered bit and accrued invalid
          nxt_exc[`FP_EXC_UNORDERED_BRANCH_FLAG] = exc_ff[`FP_EXC_UNORDERED_BRANCH_FLAG] | unordered_branch_flag; // RULE15
          nxt_accr[`FP_ACC_IOP] = accr_ff[`FP_ACC_IOP] | unordered_branch_flag; // RULE16
          nxt_words = (ea_reg == `FP_TM_WORD) ? 2'h1 :
                      (ea_reg == `FP_TM_LONG) ? 2'h2 : 2'h0; // RULE17 RULE14
          if (unordered_branch_flag && unordered_branch_flag_trap_en)
            nxt_code = fp_unit_pkg::RESP_UNORDERED_BRANCH_FLAG; // RULE18
          else if (pred_true(ext_ff[4:0], cc_ff)) // RULE13
            nxt_code = fp_unit_pkg::RESP_TRAP; // RULE11
          else
            nxt_code = fp_unit_pkg::RESP_NOTRAP; // RULE12
        end else if (is_gen && !ext_ff[14])
          go = 1'b1; // RULE8
        else if (is_gen && ea_ok && fmt != fp_unit_pkg::FMT_PACKED
                 && fmt != 3'h7)
          nxt_st = fp_unit_pkg::ST_OPND; // RULE5
        else
          nxt_code = fp_unit_pkg::RESP_ILLEGAL;
      end
      fp_unit_pkg::ST_OPND:
        go = link.opnd_valid;
      fp_unit_pkg::ST_EXEC:
      begin
        // One multiply by ten or by a tenth per cycle; truncation is inexact
        if (!neg_ff)
        begin
          nxt_m = p10[67] ? p10[67:4] : p10[66:3];
          nxt_e = e_ff + (p10[67] ? 15'h4 : 15'h3);
          nxt_inex = inex_ff | (p10[67] ? p10[3:0] != 4'h0 : p10[2:0] != 3'h0);
        end else
        begin
          nxt_m = p01[127] ? p01[127:64] : p01[126:63];
          nxt_e = e_ff - (p01[127] ? 15'h3 : 15'h4);
          nxt_inex = 1'b1;
        end
        nxt_cnt = cnt_ff - 13'h1;
        if (cnt_ff == 13'h1)
        begin
          fin = 1'b1;
          res = {1'b0, nxt_e, nxt_m};
        end
      end
      fp_unit_pkg::ST_RESP:
        nxt_st = fp_unit_pkg::ST_IDLE;
      default:
        nxt_st = fp_unit_pkg::ST_IDLE;
    endcase
    if (go)
    begin
      nxt_inex = 1'b0;
      fin = 1'b1;
      if (x[78:64] == `FP_EXP_MAX && x[62:0] != 63'h0)
      begin
        res = {x[79:63], 1'b1, x[61:0]}; // RULE19
        signaling_not_a_number_flag = !x[62];
      end else if (x[78:64] == `FP_EXP_MAX)
        res = x[79] ? 80'h0 : {1'b0, `FP_EXP_MAX, 64'h0}; // RULE2
      else if (x[78:64] == 15'h0 || ue[15])
      begin
        // Zero, denormal and pure fractions all give one
        res = {1'b0, `FP_EXT_BIAS, `FP_ONE_MANT}; // RULE2
        nxt_inex = x[63:0] != 64'h0;
      end else if (ue > `FP_POW_MAX_EXP)
      begin
        res = x[79] ? 80'h0 : {1'b0, `FP_EXP_MAX, 64'h0};
        ovf = !x[79];
        unf = x[79];
        nxt_inex = 1'b1;
      end else
      begin
        nxt_cnt = 13'(x[63:0] >> (6'h3f - 6'(ue)));
        fr_nz = (x[63:0] << (6'(ue) + 6'h1)) != 64'h0;
        nxt_inex = fr_nz;
        nxt_neg = x[79];
        nxt_m = `FP_ONE_MANT;
        nxt_e = `FP_EXT_BIAS;
        res = {1'b0, `FP_EXT_BIAS, `FP_ONE_MANT};
        if (nxt_cnt != 13'h0)
        begin
          fin = 1'b0;
          nxt_st = fp_unit_pkg::ST_EXEC;
        end
      end
    end
    if (fin)
    begin
      nxt_fpr[dst] = res; // RULE1 RULE9
      nxt_cc = cc_of(res);
      nxt_exc = 8'h0; // RULE10
      nxt_exc[`FP_EXC_SIGNALING_NOT_A_NUMBER_FLAG] = signaling_not_a_number_flag;
      nxt_exc[`FP_EXC_OVERFLOW_FLAG] = ovf;
      nxt_exc[`FP_EXC_UNDERFLOW_FLAG] = unf;
      nxt_exc[`FP_EXC_RESULT_INEXACT_FLAG] = nxt_inex;
      nxt_accr[`FP_ACC_IOP] = accr_ff[`FP_ACC_IOP] | signaling_not_a_number_flag;
      nxt_accr[`FP_ACC_OVERFLOW_FLAG] = accr_ff[`FP_ACC_OVERFLOW_FLAG] | ovf;
      nxt_accr[`FP_ACC_UNDERFLOW_FLAG] = accr_ff[`FP_ACC_UNDERFLOW_FLAG] | (unf & nxt_inex);
      nxt_accr[`FP_ACC_INEX] = accr_ff[`FP_ACC_INEX] | nxt_inex | ovf;
      nxt_code = fp_unit_pkg::RESP_DONE;
      nxt_st = fp_unit_pkg::ST_RESP;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_ff <= fp_unit_pkg::ST_IDLE;
      code_ff <= fp_unit_pkg::RESP_DONE;
      op_ff <= 16'h0;
      ext_ff <= 16'h0;
      for (int i = 0; i < 8; i++)
        fpr_ff[i] <= 80'h0;
      exc_ff <= 8'h0;
      accr_ff <= 8'h0;
      quot_ff <= 8'h0;
      cc_ff <= 4'h0;
      m_ff <= 64'h0;
      e_ff <= 15'h0;
      cnt_ff <= 13'h0;
      neg_ff <= 1'b0;
      inex_ff <= 1'b0;
      words_ff <= 2'h0;
    end else
    begin
      st_ff <= nxt_st;
      code_ff <= nxt_code;
      op_ff <= nxt_op;
      ext_ff <= nxt_ext;
      fpr_ff <= nxt_fpr;
      exc_ff <= nxt_exc;
      accr_ff <= nxt_accr;
      cc_ff <= nxt_cc;
      m_ff <= nxt_m;
      e_ff <= nxt_e;
      cnt_ff <= nxt_cnt;
      neg_ff <= nxt_neg;
      inex_ff <= nxt_inex;
      words_ff <= nxt_words;
    end
  end
endmodule
`default_nettype wire

// [fp_host_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fp_unit_params.svh"
module fp_host_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fp_link_if.host link,
  output logic trap_take,
  output logic pre_exc,
  output logic next_seq
);
  fp_unit_pkg::host_state_e st_ff, nxt_st;
  fp_unit_pkg::resp_e code_ff, nxt_code;
  logic [31:0] cmd_ff, nxt_cmd;
  logic [95:0] opnd_ff, nxt_opnd;
  logic [2:0] id_ff, nxt_id;
  logic [1:0] words_ff, nxt_words;
  logic done_ff, nxt_done;
  logic trap_ff, nxt_trap, pre_ff, nxt_pre, seq_ff, nxt_seq;
  logic wr, hit;

  assign wr = psel && penable && pwrite;
  assign hit = paddr == `FP_REG_CMD || paddr == `FP_REG_OPND0
               || paddr == `FP_REG_OPND1 || paddr == `FP_REG_OPND2
               || paddr == `FP_REG_STAT || paddr == `FP_REG_CFG;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign link.cmd_valid = st_ff == fp_unit_pkg::H_CMD;
  // Identifier inserted from config; address field zeroed for register source
  assign link.op_word = {cmd_ff[31:28], id_ff, cmd_ff[24:22], // RULE3
    (cmd_ff[24:22] == `FP_CLS_GEN && !cmd_ff[14]) ? 6'h0 : cmd_ff[21:16]}; // RULE4
  assign link.ext_word = cmd_ff[15:0];
  assign link.opnd_valid = st_ff == fp_unit_pkg::H_WAIT && link.opnd_req;
  assign link.opnd_data = opnd_ff;
  assign trap_take = trap_ff;
  assign pre_exc = pre_ff;
  assign next_seq = seq_ff;

  always_comb
  begin
    prdata = 32'h0;
    case (paddr)
      `FP_REG_CMD: prdata = cmd_ff;
      `FP_REG_OPND0: prdata = opnd_ff[31:0];
      `FP_REG_OPND1: prdata = opnd_ff[63:32];
      `FP_REG_OPND2: prdata = opnd_ff[95:64];
      `FP_REG_STAT: prdata = {25'h0, words_ff, code_ff, done_ff,
                              st_ff != fp_unit_pkg::H_IDLE};
      `FP_REG_CFG: prdata = {29'h0, id_ff};
      default: prdata = 32'h0;
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_code = code_ff;
    nxt_cmd = cmd_ff;
    nxt_opnd = opnd_ff;
    nxt_id = id_ff;
    nxt_words = words_ff;
    nxt_done = done_ff;
    nxt_trap = 1'b0;
    nxt_pre = 1'b0;
    nxt_seq = 1'b0;
    case (st_ff)
      fp_unit_pkg::H_IDLE:
        // Operand and config writes while busy would corrupt the transfer
        if (wr)
        begin
          case (paddr)
            `FP_REG_CMD:
            begin
              nxt_cmd = pwdata;
              nxt_done = 1'b0;
              nxt_st = fp_unit_pkg::H_CMD;
            end
            `FP_REG_OPND0: nxt_opnd[31:0] = pwdata;
            `FP_REG_OPND1: nxt_opnd[63:32] = pwdata;
            `FP_REG_OPND2: nxt_opnd[95:64] = pwdata;
            `FP_REG_CFG: nxt_id = pwdata[2:0];
            default: nxt_id = id_ff;
          endcase
        end
      fp_unit_pkg::H_CMD:
        if (link.cmd_ready)
          nxt_st = fp_unit_pkg::H_WAIT;
      fp_unit_pkg::H_WAIT:
        if (link.resp_valid)
        begin
          nxt_st = fp_unit_pkg::H_IDLE;
          nxt_code = link.resp_code;
          nxt_words = link.resp_words; // RULE14
          nxt_done = 1'b1;
          nxt_trap = link.resp_code == fp_unit_pkg::RESP_TRAP; // RULE11
          nxt_pre = link.resp_code == fp_unit_pkg::RESP_UNORDERED_BRANCH_FLAG; // RULE18
          nxt_seq = link.resp_code == fp_unit_pkg::RESP_NOTRAP; // RULE12
        end
      default:
        nxt_st = st_ff;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_ff <= fp_unit_pkg::H_IDLE;
      code_ff <= fp_unit_pkg::RESP_DONE;
      cmd_ff <= 32'h0;
      opnd_ff <= 96'h0;
      id_ff <= `FP_ID_DEFAULT;
      words_ff <= 2'h0;
      done_ff <= 1'b0;
      trap_ff <= 1'b0;
      pre_ff <= 1'b0;
      seq_ff <= 1'b0;
    end else
    begin
      st_ff <= nxt_st;
      code_ff <= nxt_code;
      cmd_ff <= nxt_cmd;
      opnd_ff <= nxt_opnd;
      id_ff <= nxt_id;
      words_ff <= nxt_words;
      done_ff <= nxt_done;
      trap_ff <= nxt_trap;
      pre_ff <= nxt_pre;
      seq_ff <= nxt_seq;
    end
  end
endmodule
`default_nettype wire

// [fp_link_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module fp_link_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic opnd_req,
  input wire logic opnd_valid,
  input wire logic resp_valid,
  input var fp_unit_pkg::resp_e resp_code,
  input wire logic [1:0] resp_words
);
  // ------------------------------
  // Link checks
  // ------------------------------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic tk;
  logic own;
  logic trp;
  assign tk = cmd_valid && cmd_ready;
  assign own = op_word[11:9] == 3'h1;
  // Trap class only counts when the identifier is ours
  assign trp = tk && own && op_word[8:3] == 6'h0f;
  foreign_id_a: assert property (
    tk && !own |-> ##2 resp_valid && resp_code == 3'h5)
    else $error("foreign command not refused");
  reg_ea_zero_a: assert property (
    cmd_valid && op_word[8:6] == 3'h0 && !ext_word[14]
    |-> op_word[5:0] == 6'h00)
    else $error("address field not zero");
  bad_source_a: assert property (
    tk && own && op_word[8:6] == 3'h0 && ext_word[14] &&
    (op_word[5:3] == 3'h1 || op_word[5:3] == 3'h0 && ext_word[12:10] == 3'h5)
    |-> ##2 resp_valid && resp_code == 3'h4)
    else $error("illegal source accepted");
  trap_resp_a: assert property (
    trp |-> ##2 resp_valid && resp_code inside {3'h1, 3'h2, 3'h3})
    else $error("trap answer wrong");
  trap_word_a: assert property (
    trp && op_word[2:0] == 3'h2 |-> ##2 resp_valid && resp_words == 2'h1)
    else $error("word operand count wrong");
  trap_none_a: assert property (
    trp && op_word[2:0] == 3'h4 |-> ##2 resp_valid && resp_words == 2'h0)
    else $error("empty operand count wrong");
  resp_pulse_a: assert property (
    resp_valid |=> !resp_valid && cmd_ready)
    else $error("answer not a single pulse");
  opnd_wait_a: assert property (
    opnd_req |-> opnd_valid && !cmd_ready)
    else $error("operand wait broken");
endmodule
`default_nettype wire

// [tb_fp_pow10_cond_trap.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_fp_pow10_cond_trap;
  logic sys_clk = 1'b0;
  logic reset, psel, penable, pwrite, pready, pslverr, trap_take, pre_exc;
  logic next_seq, unordered_branch_flag_trap_en, cc_load, err;
  logic [7:0] paddr, exc_byte, accr_byte, quot_byte;
  logic [31:0] pwdata, prdata, st;
  logic [3:0] cc_in, cond_codes;
  logic [2:0] reg_sel;
  logic [79:0] reg_data;
  int fails, checks_done, cyc, n_trap, n_pre, n_next;
  localparam logic [79:0] all_m = '1;
  // Integer bit of an infinity is left to the design
  localparam logic [79:0] noint_m = 80'hffff_7fff_ffff_ffff_ffff;
  fp_link_if fp_link_if_i ();
  fp_host_ctrl fp_host_ctrl_i (.sys_clk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .link(fp_link_if_i),
    .trap_take, .pre_exc, .next_seq);
  fp_pow10_trap_dev fp_pow10_trap_dev_i (.sys_clk, .reset,
    .link(fp_link_if_i), .unordered_branch_flag_trap_en, .cc_load, .cc_in, .reg_sel,
    .reg_data, .exc_byte, .accr_byte, .cond_codes, .quot_byte);
  fp_link_asserts fp_link_asserts_i (.sys_clk, .reset,
    .cmd_valid(fp_link_if_i.cmd_valid), .cmd_ready(fp_link_if_i.cmd_ready),
    .op_word(fp_link_if_i.op_word), .ext_word(fp_link_if_i.ext_word),
    .opnd_req(fp_link_if_i.opnd_req), .opnd_valid(fp_link_if_i.opnd_valid),
    .resp_valid(fp_link_if_i.resp_valid), .resp_code(fp_link_if_i.resp_code),
    .resp_words(fp_link_if_i.resp_words));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    n_trap += (trap_take === 1'b1);
    n_pre += (pre_exc === 1'b1);
    n_next += (next_seq === 1'b1);
    if (cyc == 30000)
    begin
      fails++;
      give_verdict();
    end
  end
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input logic [79:0] s, input logic [79:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    st = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c);
    apb(8'h00, 1'b1, c);
    do
      apb(8'h10, 1'b0, 32'h0);
    while (!(st[1] === 1'b1 && st[0] === 1'b0));
  endtask
  task automatic load_cc(input logic [3:0] c);
    @(posedge sys_clk);
    cc_in <= c;
    cc_load <= 1'b1;
    @(posedge sys_clk);
    cc_load <= 1'b0;
  endtask
  task automatic pow(input logic [31:0] c, o0, o1, o2, input logic [2:0] d,
    input logic [79:0] e, m);
    apb(8'h04, 1'b1, o0);
    apb(8'h08, 1'b1, o1);
    apb(8'h0c, 1'b1, o2);
    run(c);
    chk(st[4:2], 3'h0);
    reg_sel <= d;
    @(posedge sys_clk);
    chk(reg_data & m, e);
    chk(exc_byte & 8'ha5, 8'h00);
    chk(quot_byte, 8'h00);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    apb(8'h14, 1'b0, 32'h0);
    chk(st[2:0], 3'h1);
    apb(8'h20, 1'b0, 32'h0);
    chk(err, 1'b1);
    $display("register test done");
  endtask
  task automatic t_trap();
    logic [31:0] cmds [4] = '{32'hf27c_0001, 32'hf27a_0002, 32'hf27b_0001,
      32'hf27c_0004};
    logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h1, 3'h2};
    logic [1:0] words [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    int t, x;
    load_cc(4'b0100);
    for (int i = 0; i < 4; i++)
    begin
      t = n_trap;
      x = n_next;
      run(cmds[i]);
      chk(st[4:2], codes[i]);
      chk(st[6:5], words[i]);
      chk(n_trap - t, codes[i] == 3'h1);
      chk(n_next - x, codes[i] == 3'h2);
      chk(cond_codes, 4'b0100);
    end
    $display("trap test done");
  endtask
  task automatic t_unordered_branch_flag();
    logic [6:0] e;
    int p;
    load_cc(4'b0001);
    unordered_branch_flag_trap_en <= 1'b1;
    e = exc_byte[6:0];
    p = n_pre;
    run(32'hf27c_0011);
    chk(st[4:2], 3'h3);
    chk(n_pre - p, 1);
    chk(exc_byte, {1'b1, e});
    chk(accr_byte[7], 1'b1);
    chk(cond_codes, 4'b0001);
    unordered_branch_flag_trap_en <= 1'b0;
    run(32'hf27c_0001);
    chk(st[4:2], 3'h2);
    apb(8'h14, 1'b1, 32'h2);
    p = n_trap;
    run(32'hf27c_0008);
    chk(st[4:2], 3'h5);
    chk(n_trap - p, 0);
    apb(8'h14, 1'b1, 32'h1);
    $display("unordered test done");
  endtask
  task automatic t_pow();
    pow(32'hf200_0092, 32'h0, 32'h0, 32'h0, 3'h1,
      80'h3fff_8000_0000_0000_0000, all_m);
    pow(32'hf200_0492, 32'h0, 32'h0, 32'h0, 3'h1,
      80'h4002_a000_0000_0000_0000, all_m);
    pow(32'hf200_4112, 32'h2, 32'h0, 32'h0, 3'h2,
      80'h4005_c800_0000_0000_0000, all_m);
    pow(32'hf23c_5992, 32'h3, 32'h0, 32'h0, 3'h3,
      80'h4008_fa00_0000_0000_0000, all_m);
    pow(32'hf210_4792, 32'h3f80_0000, 32'h0, 32'h0, 3'h7,
      80'h4002_a000_0000_0000_0000, all_m);
    pow(32'hf23c_4a12, 32'h0, 32'h8000_0000, 32'h7fff_0000, 3'h4,
      80'h7fff_0000_0000_0000_0000, noint_m);
    pow(32'hf23c_4a92, 32'h0, 32'h8000_0000, 32'hffff_0000, 3'h5,
      80'h0, noint_m);
    pow(32'hf23c_4a12, 32'h1, 32'h8000_0000, 32'h7fff_0000, 3'h4,
      80'h7fff_c000_0000_0000_0001, all_m);
    chk(exc_byte[6], 1'b1);
    run(32'hf208_4092);
    chk(st[4:2], 3'h4);
    run(32'hf200_5492);
    chk(st[4:2], 3'h4);
    $display("power test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    unordered_branch_flag_trap_en = 1'b0;
    cc_load = 1'b0;
    cc_in = 4'h0;
    reg_sel = 3'h0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_trap();
    t_unordered_branch_flag();
    t_pow();
    give_verdict();
  end
endmodule
`default_nettype wire
